// ==== hw/tac_counter.v ====
// Saturating 10-bit up/down tracking counter
`timescale 1ns/1ps
`default_nettype none
`include "tac_defines.vh"
module tac_counter (
    input  wire                   aclk,
    input  wire                   aresetn,
    input  wire                   step,
    input  wire                   excess,
    input  wire                   deficit,
    output wire [`TAC_CODE_W-1:0] code
);
    reg [`TAC_CODE_W-1:0] code_reg;

    // Mid code is the zero-input value, a sensible start point
    always @(posedge aclk) begin
        if (!aresetn) begin
            code_reg <= `TAC_CODE_MID;
        end else if (step) begin
            if (excess && !deficit && code_reg != `TAC_CODE_MAX) begin
                code_reg <= code_reg + 10'h001;
            end else if (deficit && !excess && code_reg != `TAC_CODE_MIN) begin
                code_reg <= code_reg - 10'h001;
            end
        end
    end

    assign code = code_reg;
endmodule
`default_nettype wire

// ==== hw/tac_defines.vh ====
// Constants for the tracking converter control block
`ifndef TAC_DEFINES_VH
`define TAC_DEFINES_VH

`define TAC_CODE_W        10
`define TAC_CODE_MIN      10'h000
`define TAC_CODE_MID      10'h200
`define TAC_CODE_MAX      10'h3ff
`define TAC_BUS_W         11
`define TAC_ATTN_BIT      10
`define TAC_SETTLE_NS     150
`define TAC_CLK_NS        5
`define TAC_SETTLE_CYC    ((`TAC_SETTLE_NS + `TAC_CLK_NS - 1) / `TAC_CLK_NS)
`define TAC_CNT_W         6
`define TAC_HALF_CYC      6'h20
`define TAC_TAIL_PULSES   4'h8
`define TAC_TAIL_W        4
`define TAC_ADDR_W        4
`define TAC_OFS_CTRL      4'h0
`define TAC_OFS_STATUS    4'h4
`define TAC_OFS_RESULT    4'h8
`define TAC_CTRL_CONT_BIT 0
`define TAC_CTRL_INH_BIT  1
`define TAC_CTRL_RESET    2'h3
`define TAC_ST_DONE_BIT   16
`define TAC_ST_ACT_BIT    17
`define TAC_ST_OUT_BIT    18
`define TAC_ST_RUN_BIT    19
`define TAC_RESP_OKAY     2'h0
`define TAC_RESP_SLVERR   2'h2

`endif

// ==== hw/tac_sync.v ====
// Two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module tac_sync #(
    parameter W    = 1,
    parameter INIT = 1'b0
) (
    input  wire         aclk,
    input  wire         aresetn,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;

    // First stage feeds only the second stage
    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= {W{INIT}};
            sync_reg <= {W{INIT}};
        end else begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end

    assign q = sync_reg;
endmodule
`default_nettype wire

// ==== hw/tac_top.v ====
// Tracking converter control: converter clock, counter, hold latch, bus read, AXI4-Lite control
`timescale 1ns/1ps
`default_nettype none
`include "tac_defines.vh"
module tac_top #(
    parameter [`TAC_CNT_W-1:0] CONV_HALF_CYC = `TAC_HALF_CYC
) (
    input  wire                   aclk,
    input  wire                   aresetn,
    input  wire [`TAC_ADDR_W-1:0] s_axi_awaddr,
    input  wire                   s_axi_awvalid,
    output wire                   s_axi_awready,
    input  wire [31:0]            s_axi_wdata,
    input  wire [3:0]             s_axi_wstrb,
    input  wire                   s_axi_wvalid,
    output wire                   s_axi_wready,
    output wire [1:0]             s_axi_bresp,
    output wire                   s_axi_bvalid,
    input  wire                   s_axi_bready,
    input  wire [`TAC_ADDR_W-1:0] s_axi_araddr,
    input  wire                   s_axi_arvalid,
    output wire                   s_axi_arready,
    output wire [31:0]            s_axi_rdata,
    output wire [1:0]             s_axi_rresp,
    output wire                   s_axi_rvalid,
    input  wire                   s_axi_rready,
    input  wire                   level_read_strobe_n,
    input  wire                   attenuator_present_n,
    input  wire                   comp_excess,
    input  wire                   comp_deficit,
    input  wire                   above_window_n,
    input  wire                   below_window_n,
    output wire [`TAC_BUS_W-1:0]  data_bus_out,
    output wire                   data_bus_oe,
    output wire [`TAC_CODE_W-1:0] dac_code,
    output wire                   conv_clk,
    output wire                   conversion_done_request
);
    localparam integer          SETTLE_CYC = `TAC_SETTLE_CYC;
    localparam [`TAC_CNT_W-1:0] SETTLE     = SETTLE_CYC[`TAC_CNT_W-1:0];

    // Pin synchronisers; idle levels of the active-low pins are high
    wire [3:0] pins_hi_s;
    wire [1:0] pins_lo_s;
    wire       rd_n_s;
    wire       attn_n_s;
    wire       above_n_s;
    wire       below_n_s;
    wire       excess_s;
    wire       deficit_s;

    tac_sync #(.W(4), .INIT(1'b1)) u_sync_hi (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       ({level_read_strobe_n, attenuator_present_n, above_window_n, below_window_n}),
        .q       (pins_hi_s)
    );
    tac_sync #(.W(2), .INIT(1'b0)) u_sync_lo (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       ({comp_excess, comp_deficit}),
        .q       (pins_lo_s)
    );
    assign rd_n_s    = pins_hi_s[3];
    assign attn_n_s  = pins_hi_s[2];
    assign above_n_s = pins_hi_s[1];
    assign below_n_s = pins_hi_s[0];
    assign excess_s  = pins_lo_s[1];
    assign deficit_s = pins_lo_s[0];

    // Threshold comparison is analog; each detector arrives as an open-collector low
    wire outside_window_n = above_n_s & below_n_s;
    wire outside_window   = ~outside_window_n;

    reg  [1:0]             ctrl_reg;
    reg                    rd_n_d_reg;
    reg                    active_reg;
    reg                    done_req_reg;
    reg  [`TAC_TAIL_W-1:0] tail_reg;
    reg                    gate_reg;
    reg                    conv_clk_reg;
    reg  [`TAC_CNT_W-1:0]  phase_reg;
    reg  [`TAC_CNT_W-1:0]  since_rise_reg;
    reg  [`TAC_CODE_W-1:0] latch_reg;
    reg  [`TAC_BUS_W-1:0]  bus_reg;
    reg                    oe_reg;

    wire cont_n    = ctrl_reg[`TAC_CTRL_CONT_BIT];
    wire inhibit_n = ctrl_reg[`TAC_CTRL_INH_BIT];
    wire read_fall = rd_n_d_reg & ~rd_n_s;
    wire half_done = (phase_reg == CONV_HALF_CYC - 6'h01);
    wire rise      = gate_reg & half_done & ~conv_clk_reg;
    wire [`TAC_CODE_W-1:0] code;

    // Request or idle stops the clock unless continuous mode forces it
    wire run_want = inhibit_n
                  & rd_n_s
                  & (~cont_n | (active_reg & ~done_req_reg));

    tac_counter u_counter (
        .aclk    (aclk),
        .aresetn (aresetn),
        .step    (rise),
        .excess  (excess_s),
        .deficit (deficit_s),
        .code    (code)
    );

    // Converter clock idles high; gate only moves during the high phase, never at the
    // edge that ends it, or the clock would stop low with the gate unable to reopen
    always @(posedge aclk) begin
        if (!aresetn) begin
            gate_reg     <= 1'b0;
            conv_clk_reg <= 1'b1;
            phase_reg    <= {`TAC_CNT_W{1'b0}};
        end else begin
            if (conv_clk_reg && !(gate_reg && half_done)) begin
                gate_reg <= run_want;
            end
            if (!gate_reg) begin
                phase_reg <= {`TAC_CNT_W{1'b0}};
            end else if (half_done) begin
                phase_reg    <= {`TAC_CNT_W{1'b0}};
                conv_clk_reg <= ~conv_clk_reg;
            end else begin
                phase_reg <= phase_reg + 6'h01;
            end
        end
    end

    // Conversion start, eight-pulse tail and completion request
    always @(posedge aclk) begin
        if (!aresetn) begin
            rd_n_d_reg   <= 1'b1;
            active_reg   <= 1'b0;
            done_req_reg <= 1'b0;
            tail_reg     <= {`TAC_TAIL_W{1'b0}};
        end else begin
            rd_n_d_reg <= rd_n_s;
            if (outside_window) begin
                active_reg <= 1'b1;
                tail_reg   <= {`TAC_TAIL_W{1'b0}};
            end else if (rise && active_reg) begin
                if (tail_reg == `TAC_TAIL_PULSES - 4'h1) begin
                    active_reg <= 1'b0;
                    tail_reg   <= {`TAC_TAIL_W{1'b0}};
                end else begin
                    tail_reg <= tail_reg + 4'h1;
                end
            end
            // Completion beats a read clear in the same cycle
            if (rise && active_reg && !outside_window && tail_reg == `TAC_TAIL_PULSES - 4'h1) begin
                done_req_reg <= 1'b1;
            end else if (read_fall) begin
                done_req_reg <= 1'b0;
            end
        end
    end

    // Transparent while the strobe is high and at an unsettled strobe fall; frozen for the read otherwise
    wire                   latch_open = rd_n_s
                                      | (read_fall & (since_rise_reg != SETTLE));
    wire [`TAC_CODE_W-1:0] latch_next = latch_open ? code : latch_reg;

    // Capture stays open one more cycle at the strobe fall if a rising edge came within the settle time
    always @(posedge aclk) begin
        if (!aresetn) begin
            since_rise_reg <= {`TAC_CNT_W{1'b0}};
            latch_reg      <= `TAC_CODE_MID;
            bus_reg        <= {`TAC_BUS_W{1'b0}};
            oe_reg         <= 1'b0;
        end else begin
            if (rise) begin
                since_rise_reg <= {`TAC_CNT_W{1'b0}};
            end else if (since_rise_reg != SETTLE) begin
                since_rise_reg <= since_rise_reg + 6'h01;
            end
            latch_reg                <= latch_next;
            // Bus code field takes the same value, so the code never moves once it is driven
            bus_reg[`TAC_CODE_W-1:0] <= latch_next;
            bus_reg[`TAC_ATTN_BIT]   <= attn_n_s;
            oe_reg                   <= ~rd_n_s;
        end
    end

    // AXI4-Lite slave: one write and one read at a time
    reg        aw_hold_reg;
    reg        w_hold_reg;
    reg [`TAC_ADDR_W-1:0] awaddr_reg;
    reg [31:0] wdata_reg;
    reg [3:0]  wstrb_reg;
    reg        bvalid_reg;
    reg [1:0]  bresp_reg;
    reg        rvalid_reg;
    reg [31:0] rdata_reg;
    reg [1:0]  rresp_reg;

    wire aw_take = s_axi_awvalid & ~aw_hold_reg & ~bvalid_reg;
    wire w_take  = s_axi_wvalid & ~w_hold_reg & ~bvalid_reg;
    wire have_aw = aw_hold_reg | aw_take;
    wire have_w  = w_hold_reg | w_take;
    wire [`TAC_ADDR_W-1:0] wa = aw_hold_reg ? awaddr_reg : s_axi_awaddr;
    wire [31:0] wd  = w_hold_reg ? wdata_reg : s_axi_wdata;
    wire [3:0]  ws  = w_hold_reg ? wstrb_reg : s_axi_wstrb;
    wire        do_write = have_aw & have_w & ~bvalid_reg;

    function addr_known;
        input [`TAC_ADDR_W-1:0] a;
        begin
            addr_known = (a == `TAC_OFS_CTRL) | (a == `TAC_OFS_STATUS) | (a == `TAC_OFS_RESULT);
        end
    endfunction

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg  <= 1'b0;
            awaddr_reg  <= {`TAC_ADDR_W{1'b0}};
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `TAC_RESP_OKAY;
            ctrl_reg    <= `TAC_CTRL_RESET;
        end else begin
            if (do_write) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= addr_known(wa) ? `TAC_RESP_OKAY : `TAC_RESP_SLVERR;
                if (wa == `TAC_OFS_CTRL && ws[0]) begin
                    ctrl_reg <= wd[1:0];
                end
            end else begin
                if (aw_take) begin
                    aw_hold_reg <= 1'b1;
                    awaddr_reg  <= s_axi_awaddr;
                end
                if (w_take) begin
                    w_hold_reg <= 1'b1;
                    wdata_reg  <= s_axi_wdata;
                    wstrb_reg  <= s_axi_wstrb;
                end
                if (bvalid_reg && s_axi_bready) begin
                    bvalid_reg <= 1'b0;
                end
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= `TAC_RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= addr_known(s_axi_araddr) ? `TAC_RESP_OKAY : `TAC_RESP_SLVERR;
            rdata_reg  <= 32'h0000_0000;
            case (s_axi_araddr)
                `TAC_OFS_CTRL: begin
                    rdata_reg[1:0] <= ctrl_reg;
                end
                `TAC_OFS_STATUS: begin
                    rdata_reg[`TAC_CODE_W-1:0]  <= code;
                    rdata_reg[`TAC_ST_DONE_BIT] <= done_req_reg;
                    rdata_reg[`TAC_ST_ACT_BIT]  <= active_reg;
                    rdata_reg[`TAC_ST_OUT_BIT]  <= outside_window;
                    rdata_reg[`TAC_ST_RUN_BIT]  <= gate_reg;
                end
                `TAC_OFS_RESULT: begin
                    rdata_reg[`TAC_BUS_W-1:0] <= {attn_n_s, latch_reg};
                end
                default: begin
                    rdata_reg <= 32'h0000_0000;
                end
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_awready = aw_take;
    assign s_axi_wready  = w_take;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = ~rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    assign data_bus_out            = bus_reg;
    assign data_bus_oe             = oe_reg;
    assign dac_code                = code;
    assign conv_clk                = conv_clk_reg;
    assign conversion_done_request = done_req_reg;
endmodule
`default_nettype wire

// ==== testbench/tac_monitor.sv ====
// Port checker for the tracking converter control block
`timescale 1ns/1ps
`default_nettype none
module tac_monitor #(
    parameter [5:0] CONV_HALF_CYC = 6'h20
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        level_read_strobe_n,
    input wire logic        attenuator_present_n,
    input wire logic [10:0] data_bus_out,
    input wire logic        data_bus_oe,
    input wire logic [9:0]  dac_code,
    input wire logic        conv_clk,
    input wire logic        conversion_done_request
);
    default clocking mon_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Strobe low time, so the clock stop is judged only after the gate had a full converter clock period to act
    logic [7:0] low_cnt_reg;
    always @(posedge aclk) begin
        if (!aresetn || level_read_strobe_n)
            low_cnt_reg <= 8'h00;
        else if (low_cnt_reg != 8'hff)
            low_cnt_reg <= low_cnt_reg + 8'h01;
    end

    bus_drive_a: assert property (!level_read_strobe_n [*5] |-> data_bus_oe)
        else $error("bus not driven during read");
    bus_release_a: assert property (level_read_strobe_n [*5] |-> !data_bus_oe)
        else $error("bus driven without read");
    result_frozen_a: assert property (data_bus_oe && $past(data_bus_oe) |-> $stable(data_bus_out[9:0]))
        else $error("result changed during read");
    atten_flag_a: assert property ($stable(attenuator_present_n) [*4] ##0 data_bus_oe
        |-> data_bus_out[10] == attenuator_present_n)
        else $error("attenuator flag wrong");
    read_clk_stop_a: assert property (low_cnt_reg > {CONV_HALF_CYC, 1'b0} + 8'h06
        |-> conv_clk && $stable(conv_clk))
        else $error("converter clock ran during read");
    unit_step_a: assert property (!$stable(dac_code)
        |-> dac_code == $past(dac_code) + 1 || dac_code == $past(dac_code) - 1)
        else $error("counter moved by more than one");
    step_on_rise_a: assert property (!$stable(dac_code) |-> conv_clk && !$past(conv_clk) && !$past(conv_clk, 3))
        else $error("counter moved without clock rise");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write response late");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");

    cover property ($rose(data_bus_oe));
    cover property ($rose(conversion_done_request));
    cover property (dac_code == 10'h3ff [*2]);
    cover property (s_axi_bvalid && s_axi_bready);
endmodule
`default_nettype wire

// ==== testbench/tac_proc_model.sv ====
// Processor-side model of the parallel result read
`timescale 1ns/1ps
`default_nettype none
module tac_proc_model (
    input  wire logic        aclk,
    input  wire logic [10:0] data_bus_out,
    input  wire logic        data_bus_oe,
    output var  logic        level_read_strobe_n
);
    logic [10:0] last_reg = 11'h000;
    // A released bus keeps no value, so a late sample cannot match by luck
    wire  [10:0] bus_seen = data_bus_oe ? data_bus_out : ~last_reg;

    initial level_read_strobe_n = 1'b1;

    task automatic read_level(input int dwell, output logic [10:0] v);
        level_read_strobe_n <= 1'b0;
        repeat (dwell + 4) @(posedge aclk);
        @(negedge aclk);
        v = bus_seen;
        last_reg = v;
        @(posedge aclk);
        level_read_strobe_n <= 1'b1;
        repeat (8) @(posedge aclk);
    endtask
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the tracking converter control block
`timescale 1ns/1ps
`default_nettype none
`include "tac_defines.vh"
module testbench;
    localparam logic [5:0] HALF = 6'h04;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic        level_read_strobe_n, attenuator_present_n = 1'b1;
    logic        comp_excess = 1'b0, comp_deficit = 1'b0, above_window_n = 1'b1, below_window_n = 1'b1;
    logic [10:0] data_bus_out, bus;
    logic        data_bus_oe, conv_clk, conversion_done_request, prev;
    logic [9:0]  dac_code;
    int          fails = 0, tests_run = 0, tgt = 512, exp_code, n;

    always #2.5 aclk = ~aclk;

    tac_top #(.CONV_HALF_CYC(HALF)) u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .level_read_strobe_n, .attenuator_present_n, .comp_excess, .comp_deficit, .above_window_n,
        .below_window_n, .data_bus_out, .data_bus_oe, .dac_code, .conv_clk, .conversion_done_request);

    tac_proc_model u_proc (.aclk, .data_bus_out, .data_bus_oe, .level_read_strobe_n);

    // Analog loop: summing-node comparator and the wired-OR window detectors
    always @(posedge aclk) begin
        comp_excess <= int'(dac_code) < tgt;
        comp_deficit <= int'(dac_code) > tgt;
        above_window_n <= !(int'(dac_code) < tgt - 1);
        below_window_n <= !(int'(dac_code) > tgt + 1);
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            @(posedge aclk);
            if (ta)
                s_axi_awvalid <= 1'b0;
            if (tw)
                s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !ta) || (s_axi_wvalid && !tw));
        s_axi_bready <= 1'b1;
        do @(negedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(negedge aclk); while (!s_axi_arready);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(negedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask

    initial begin
        #(90000 * 5);
        fails++;
        report_and_stop;
    end

    initial begin
        rd = $urandom(75);
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(negedge aclk);
        chk("reset code", `TAC_CODE_MID, dac_code);
        chk("reset request", 0, conversion_done_request);
        @(posedge aclk);
        axi_rd(`TAC_OFS_CTRL, rd, rs);
        chk("ctrl reset", `TAC_CTRL_RESET, rd);
        axi_wr(4'hc, 32'h0, rs);
        chk("unmapped write", `TAC_RESP_SLVERR, rs);
        axi_rd(4'hc, rd, rs);
        chk("unmapped read", `TAC_RESP_SLVERR, rs);
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            tgt = (i == 0) ? 1100 : (i == 1) ? -40 : $urandom_range(1023, 0);
            // A target within one code of the last result sits inside the window and starts nothing
            while (i > 1 && tgt >= exp_code - 1 && tgt <= exp_code + 1)
                tgt = $urandom_range(1023, 0);
            attenuator_present_n <= 1'($urandom_range(1, 0));
            repeat (10000) @(posedge aclk);
            @(negedge aclk);
            exp_code = tgt < 0 ? 0 : tgt > 1023 ? 1023 : tgt;
            chk("settled code", exp_code, dac_code);
            chk("done request", tgt >= 0 && tgt <= 1023, conversion_done_request);
            rd = 32'(dac_code);
            repeat (50) @(negedge aclk);
            chk("idle in window", rd, dac_code);
            @(posedge aclk);
            u_proc.read_level((i == 0) ? 24 : $urandom_range(12, 1), bus);
            chk("bus code", exp_code, bus[9:0]);
            chk("bus flag", attenuator_present_n, bus[10]);
            chk("request cleared", 0, conversion_done_request);
            $display("test tracking %0d done", i);
        end
        axi_wr(`TAC_OFS_CTRL, 32'h1, rs);
        tgt = exp_code > 511 ? exp_code - 200 : exp_code + 200;
        repeat (600) @(negedge aclk);
        chk("inhibit hold", exp_code, dac_code);
        @(posedge aclk);
        axi_wr(`TAC_OFS_CTRL, 32'h3, rs);
        repeat (3000) @(posedge aclk);
        axi_rd(`TAC_OFS_STATUS, rd, rs);
        chk("restart code", tgt, rd[9:0]);
        chk("status done", 1, rd[`TAC_ST_DONE_BIT]);
        chk("status gate", 0, rd[`TAC_ST_RUN_BIT]);
        axi_rd(`TAC_OFS_RESULT, rd, rs);
        chk("result reg", {attenuator_present_n, 10'(tgt)}, rd);
        axi_wr(`TAC_OFS_CTRL, 32'h2, rs);
        axi_rd(`TAC_OFS_CTRL, rd, rs);
        chk("ctrl readback", 32'h2, rd);
        n = 0;
        prev = conv_clk;
        repeat (100) begin
            @(negedge aclk);
            if (conv_clk && !prev)
                n++;
            prev = conv_clk;
        end
        chk("free run", 1, n >= 10);
        $display("test control done");
        report_and_stop;
    end
endmodule

bind tac_top tac_monitor #(.CONV_HALF_CYC(CONV_HALF_CYC)) u_mon (.*);
`default_nettype wire
